/* logic/rcs_top.sv */
// Reset qualification, clock division, power modes, ports and special registers.
`timescale 1ns/1ns
`default_nettype none
module rcs_top (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_reset_pin,
  input  wire logic                          i_osc_input_pin,
  output logic                               o_osc_output_pin,
  input  wire logic [rcs_pkg::DATA_W-1:0]    i_p1_pin,
  output logic      [rcs_pkg::DATA_W-1:0]    o_p1_pin,
  output logic      [rcs_pkg::DATA_W-1:0]    o_p1_pin_oe,
  input  wire logic [rcs_pkg::DATA_W-1:0]    i_p3_pin,
  output logic      [rcs_pkg::DATA_W-1:0]    o_p3_pin,
  output logic      [rcs_pkg::DATA_W-1:0]    o_p3_pin_oe,
  input  wire logic                          i_comparator_result,
  input  wire logic                          i_serial_tx,
  output logic                               o_serial_rx,
  output logic                               o_ext_irq_zero,
  output logic                               o_ext_irq_one,
  output logic                               o_timer_zero_count_in,
  output logic                               o_timer_one_count_in,
  input  wire logic [rcs_pkg::NUM_VEC-1:0]   i_irq_req,
  output logic                               o_irq_valid,
  output logic      [2:0]                    o_irq_vec,
  output logic                               o_irq_high,
  output logic                               o_mcycle,
  output logic                               o_core_reset,
  output logic                               o_cpu_halt,
  output logic                               o_periph_run,
  output logic                               o_osc_stop,
  input  wire logic [rcs_pkg::ADDR_W-1:0]    i_reg_addr,
  input  wire logic [rcs_pkg::DATA_W-1:0]    i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic      [rcs_pkg::DATA_W-1:0]    o_reg_rdata
);

  localparam int unsigned SYNC_W = 2 * rcs_pkg::DATA_W + 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'b000, {(2 * rcs_pkg::DATA_W){1'b1}}};

  logic [SYNC_W-1:0]             meta_ff;
  logic [SYNC_W-1:0]             sync_ff;
  logic                          osc_prev_ff;
  logic                          div2_ff;
  logic [2:0]                    mc_cnt_ff;
  logic                          mcycle_ff;
  logic [1:0]                    rst_cnt_ff;
  logic                          core_reset_ff;
  logic                          idle_ff;
  logic                          pd_ff;
  logic [rcs_pkg::DATA_W-1:0]    plain_ff [rcs_pkg::NUM_PLAIN];
  logic [rcs_pkg::DATA_W-1:0]    ip_ff;
  logic [rcs_pkg::DATA_W-1:0]    ie_ff;
  logic [rcs_pkg::DATA_W-1:0]    p1_latch_ff;
  logic [rcs_pkg::DATA_W-1:0]    p3_latch_ff;
  logic [rcs_pkg::DATA_W-1:0]    p1_oe_ff;
  logic [rcs_pkg::DATA_W-1:0]    p3_oe_ff;
  logic [rcs_pkg::DATA_W-1:0]    rdata_ff;
  logic [4:0]                    alt_ff;
  logic                          irq_valid_ff;
  logic [2:0]                    irq_vec_ff;
  logic                          irq_high_ff;
  logic                          osc_out_ff;
  logic                          rst_s;
  logic                          osc_s;
  logic                          cmp_s;
  logic [rcs_pkg::DATA_W-1:0]    p1_s;
  logic [rcs_pkg::DATA_W-1:0]    p3_s;
  logic                          osc_rise;
  logic                          div2_rise;
  logic                          wr_hit;
  logic [rcs_pkg::DATA_W-1:0]    nxt_rdata;
  logic [rcs_pkg::DATA_W-1:0]    p3_read;
  logic [rcs_pkg::DATA_W-1:0]    p3_drive;
  logic                          nxt_irq_valid;
  logic [2:0]                    nxt_irq_vec;
  logic                          nxt_irq_high;

  // Pins pass two flip-flops; port bits reset high so no false edge follows reset.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= {i_reset_pin, i_osc_input_pin, i_comparator_result, i_p1_pin, i_p3_pin};
      sync_ff <= meta_ff;
    end
  end

  assign rst_s = sync_ff[SYNC_W-1];
  assign osc_s = sync_ff[SYNC_W-2];
  assign cmp_s = sync_ff[SYNC_W-3];
  assign p1_s  = sync_ff[2*rcs_pkg::DATA_W-1:rcs_pkg::DATA_W];
  assign p3_s  = sync_ff[rcs_pkg::DATA_W-1:0];

  // A stopped oscillator yields no edges, so the whole cycle chain freezes.
  assign osc_rise  = osc_s & ~osc_prev_ff & ~pd_ff;
  assign div2_rise = osc_rise & ~div2_ff;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_prev_ff <= 1'b0;
      div2_ff     <= 1'b0;
    end else begin
      osc_prev_ff <= osc_s;
      if (osc_rise) begin
        div2_ff <= ~div2_ff;
      end
    end
  end

  // Six halved periods make one machine cycle of twelve oscillator periods.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mc_cnt_ff <= '0;
      mcycle_ff <= 1'b0;
    end else begin
      mcycle_ff <= 1'b0;
      if (div2_rise) begin
        if (mc_cnt_ff == 3'(rcs_pkg::DIV2_PER_MC - 1)) begin
          mc_cnt_ff <= '0;
          mcycle_ff <= 1'b1;
        end else begin
          mc_cnt_ff <= mc_cnt_ff + 3'h1;
        end
      end
    end
  end

  // A low sample restarts the count; the third pulse proves two whole cycles of hold.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_cnt_ff    <= '0;
      core_reset_ff <= 1'b0;
    end else if (!rst_s) begin
      rst_cnt_ff    <= '0;
      core_reset_ff <= 1'b0;
    end else begin
      if (mcycle_ff && rst_cnt_ff != 2'(rcs_pkg::RST_MCYC + 1)) begin
        rst_cnt_ff <= rst_cnt_ff + 2'h1;
      end
      core_reset_ff <= (rst_cnt_ff == 2'(rcs_pkg::RST_MCYC + 1));
    end
  end

  assign wr_hit = i_reg_wr & ~core_reset_ff;

  // Idle ends on a selected interrupt; power-down waits for the reset pin.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idle_ff <= 1'b0;
      pd_ff   <= 1'b0;
    end else if (core_reset_ff) begin
      idle_ff <= 1'b0;
      pd_ff   <= 1'b0;
    end else begin
      if (wr_hit && i_reg_addr == rcs_pkg::OFS_PWR) begin
        idle_ff <= i_reg_wdata[rcs_pkg::PWR_IDLE_BIT];
        pd_ff   <= i_reg_wdata[rcs_pkg::PWR_PD_BIT];
      end else begin
        if (irq_valid_ff) begin
          idle_ff <= 1'b0;
        end
        if (rst_s) begin
          pd_ff <= 1'b0;
        end
      end
    end
  end

  // Plain storage registers, indexed by their own offset.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < rcs_pkg::NUM_PLAIN; i++) begin
        plain_ff[i] <= rcs_pkg::RST_ZERO;
      end
    end else if (core_reset_ff) begin
      for (int i = 0; i < rcs_pkg::NUM_PLAIN; i++) begin
        plain_ff[i] <= rcs_pkg::RST_ZERO;
      end
    end else if (wr_hit && i_reg_addr < rcs_pkg::ADDR_W'(rcs_pkg::NUM_PLAIN)) begin
      plain_ff[i_reg_addr[3:0]] <= i_reg_wdata;
    end
  end

  // Unused priority and enable bits never store ones.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ip_ff <= rcs_pkg::RST_ZERO;
      ie_ff <= rcs_pkg::RST_ZERO;
    end else if (core_reset_ff) begin
      ip_ff <= rcs_pkg::RST_ZERO;
      ie_ff <= rcs_pkg::RST_ZERO;
    end else if (wr_hit) begin
      if (i_reg_addr == rcs_pkg::OFS_IP) begin
        ip_ff <= i_reg_wdata & rcs_pkg::IP_MASK;
      end
      if (i_reg_addr == rcs_pkg::OFS_IE) begin
        ie_ff <= i_reg_wdata & rcs_pkg::IE_MASK;
      end
    end
  end

  // The raw reset pin presets the latches so ports float high before any clock.
  always_ff @(posedge i_core_clk or negedge i_rst_b or posedge i_reset_pin) begin
    if (!i_rst_b) begin
      p1_latch_ff <= rcs_pkg::RST_PORT;
      p3_latch_ff <= rcs_pkg::RST_PORT;
    end else if (i_reset_pin) begin
      p1_latch_ff <= rcs_pkg::RST_PORT;
      p3_latch_ff <= rcs_pkg::RST_PORT;
    end else if (wr_hit) begin
      if (i_reg_addr == rcs_pkg::OFS_P1) begin
        p1_latch_ff <= i_reg_wdata;
      end
      if (i_reg_addr == rcs_pkg::OFS_P3) begin
        p3_latch_ff <= i_reg_wdata;
      end
    end
  end

  // The serial transmitter pin is pulled low while its latch bit or the transmitter output is zero.
  always_comb begin
    p3_drive = ~p3_latch_ff;
    p3_drive[rcs_pkg::P3_TX_BIT] = ~(p3_latch_ff[rcs_pkg::P3_TX_BIT] & i_serial_tx);
    p3_drive[rcs_pkg::P3_CMP_BIT] = 1'b0;
  end

  // Pins only ever sink; a latch bit of one releases the pin for input use.
  always_ff @(posedge i_core_clk or negedge i_rst_b or posedge i_reset_pin) begin
    if (!i_rst_b) begin
      p1_oe_ff <= '0;
      p3_oe_ff <= '0;
    end else if (i_reset_pin) begin
      p1_oe_ff <= '0;
      p3_oe_ff <= '0;
    end else begin
      p1_oe_ff <= ~p1_latch_ff;
      p3_oe_ff <= p3_drive;
    end
  end

  // Alternate inputs follow the synchronised pins of port three.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      alt_ff <= '1;
    end else begin
      alt_ff <= {p3_s[rcs_pkg::P3_CNT1_BIT], p3_s[rcs_pkg::P3_CNT0_BIT],
                 p3_s[rcs_pkg::P3_IRQ1_BIT], p3_s[rcs_pkg::P3_IRQ0_BIT],
                 p3_s[rcs_pkg::P3_RX_BIT]};
    end
  end

  // High-priority requests win; within a level the lowest index wins.
  always_comb begin
    nxt_irq_valid = 1'b0;
    nxt_irq_vec   = '0;
    nxt_irq_high  = 1'b0;
    if (ie_ff[rcs_pkg::IE_ALL_BIT]) begin
      for (int i = rcs_pkg::NUM_VEC - 1; i >= 0; i--) begin
        if (i_irq_req[i] && ie_ff[i] && !ip_ff[i] && !nxt_irq_high) begin
          nxt_irq_valid = 1'b1;
          nxt_irq_vec   = 3'(i);
        end
      end
      for (int i = rcs_pkg::NUM_VEC - 1; i >= 0; i--) begin
        if (i_irq_req[i] && ie_ff[i] && ip_ff[i]) begin
          nxt_irq_valid = 1'b1;
          nxt_irq_high  = 1'b1;
          nxt_irq_vec   = 3'(i);
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_valid_ff <= 1'b0;
      irq_vec_ff   <= '0;
      irq_high_ff  <= 1'b0;
    end else begin
      irq_valid_ff <= nxt_irq_valid & ~core_reset_ff;
      irq_vec_ff   <= nxt_irq_vec;
      irq_high_ff  <= nxt_irq_high;
    end
  end

  // Port reads see the pins, and bit six of port three is the comparator.
  always_comb begin
    p3_read = p3_s;
    p3_read[rcs_pkg::P3_CMP_BIT] = cmp_s;
  end

  // Unused addresses answer zero, which is a safe form of undefined data.
  always_comb begin
    nxt_rdata = rcs_pkg::RST_ZERO;
    if (i_reg_addr < rcs_pkg::ADDR_W'(rcs_pkg::NUM_PLAIN)) begin
      nxt_rdata = plain_ff[i_reg_addr[3:0]];
    end else begin
      case (i_reg_addr)
        rcs_pkg::OFS_IP:  nxt_rdata = ip_ff;
        rcs_pkg::OFS_IE:  nxt_rdata = ie_ff;
        rcs_pkg::OFS_P1:  nxt_rdata = p1_s;
        rcs_pkg::OFS_P3:  nxt_rdata = p3_read;
        rcs_pkg::OFS_PWR: begin
          nxt_rdata = rcs_pkg::RST_ZERO;
          nxt_rdata[rcs_pkg::PWR_IDLE_BIT] = idle_ff;
          nxt_rdata[rcs_pkg::PWR_PD_BIT]   = pd_ff;
        end
        default:          nxt_rdata = rcs_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= i_reg_rd ? nxt_rdata : rcs_pkg::RST_ZERO;
    end
  end

  // The amplifier output mirrors the inverted input until power-down stops it.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_out_ff <= 1'b0;
    end else begin
      osc_out_ff <= ~osc_s & ~pd_ff;
    end
  end

  assign o_osc_output_pin      = osc_out_ff;
  assign o_p1_pin              = '0;
  assign o_p3_pin              = '0;
  assign o_p1_pin_oe           = p1_oe_ff;
  assign o_p3_pin_oe           = p3_oe_ff;
  assign o_serial_rx           = alt_ff[0];
  assign o_ext_irq_zero        = alt_ff[1];
  assign o_ext_irq_one         = alt_ff[2];
  assign o_timer_zero_count_in = alt_ff[3];
  assign o_timer_one_count_in  = alt_ff[4];
  assign o_irq_valid           = irq_valid_ff;
  assign o_irq_vec             = irq_vec_ff;
  assign o_irq_high            = irq_high_ff;
  assign o_mcycle              = mcycle_ff;
  assign o_core_reset          = core_reset_ff;
  assign o_cpu_halt            = idle_ff | pd_ff;
  assign o_periph_run          = ~pd_ff;
  assign o_osc_stop            = pd_ff;
  assign o_reg_rdata           = rdata_ff;

endmodule : rcs_top
`default_nettype wire

/* logic/rcs_pkg.sv */
// Constants shared by the reset, clock and special register block.
package rcs_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned NUM_VEC     = 5;
  localparam int unsigned OSC_PER_MC  = 12;
  localparam int unsigned DIV2_PER_MC = OSC_PER_MC / 2;
  localparam int unsigned RST_MCYC    = 2;
  localparam logic [ADDR_W-1:0] OFS_AUX   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WORK  = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_PSW   = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_SERIAL_CONTROL  = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_SERIAL_BUFFER  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL  = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_TIMER_MODE_SELECT  = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_TL0   = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_TL1   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TH0   = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_TH1   = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_IP    = 8'h0B;
  localparam logic [ADDR_W-1:0] OFS_IE    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_P1    = 8'h0D;
  localparam logic [ADDR_W-1:0] OFS_P3    = 8'h0E;
  localparam logic [ADDR_W-1:0] OFS_PWR   = 8'h0F;
  localparam int unsigned NUM_PLAIN = 11;
  localparam logic [DATA_W-1:0] RST_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT  = 8'hFF;
  localparam logic [DATA_W-1:0] IP_MASK   = 8'h1F;
  localparam logic [DATA_W-1:0] IE_MASK   = 8'h9F;
  localparam logic [DATA_W-1:0] PWR_MASK  = 8'h03;
  localparam int unsigned IE_ALL_BIT  = 7;
  localparam int unsigned PWR_IDLE_BIT = 0;
  localparam int unsigned PWR_PD_BIT  = 1;
  localparam int unsigned P3_RX_BIT   = 0;
  localparam int unsigned P3_TX_BIT   = 1;
  localparam int unsigned P3_IRQ0_BIT = 2;
  localparam int unsigned P3_IRQ1_BIT = 3;
  localparam int unsigned P3_CNT0_BIT = 4;
  localparam int unsigned P3_CNT1_BIT = 5;
  localparam int unsigned P3_CMP_BIT  = 6;
endpackage : rcs_pkg

/* verification/rcs_props.sv */
// Port-level assertions for the reset, clock and special register block.
`timescale 1ns/1ns
`default_nettype none
module rcs_props (
  input wire logic                        i_core_clk,
  input wire logic                        i_rst_b,
  input wire logic                        i_reset_pin,
  input wire logic [rcs_pkg::DATA_W-1:0]  i_p3_pin,
  input wire logic [rcs_pkg::NUM_VEC-1:0] i_irq_req,
  input wire logic [rcs_pkg::ADDR_W-1:0]  i_reg_addr,
  input wire logic [rcs_pkg::DATA_W-1:0]  i_reg_wdata,
  input wire logic                        i_reg_wr,
  input wire logic                        i_reg_rd,
  input wire logic [rcs_pkg::DATA_W-1:0]  o_p1_pin_oe,
  input wire logic [rcs_pkg::DATA_W-1:0]  o_p3_pin_oe,
  input wire logic                        o_serial_rx,
  input wire logic                        o_timer_one_count_in,
  input wire logic                        o_irq_valid,
  input wire logic                        o_mcycle,
  input wire logic                        o_core_reset,
  input wire logic                        o_cpu_halt,
  input wire logic                        o_periph_run,
  input wire logic                        o_osc_stop,
  input wire logic                        o_osc_output_pin,
  input wire logic [rcs_pkg::DATA_W-1:0]  o_reg_rdata
);
  int unsigned hi_cnt_ff;
  // Saturates so that a long hold never wraps back below the qualification bound.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_cnt_ff <= 0;
    end else begin
      hi_cnt_ff <= !i_reset_pin ? 0 : (hi_cnt_ff < 1000) ? hi_cnt_ff + 1 : hi_cnt_ff;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_port_preset: assert property (i_reset_pin |-> o_p1_pin_oe == 8'h00)
    else $error("port one still driven while reset pin high");
  a_cmp_bit_free: assert property (o_p3_pin_oe[6] == 1'b0)
    else $error("comparator bit of port three driven");
  a_mcycle_pulse: assert property (o_mcycle |=> !o_mcycle [*8])
    else $error("machine cycle pulse too long or too close");
  // Two machine cycles are 192 core clocks with the bench oscillator of eight clocks a period.
  a_qual_length: assert property ($rose(o_core_reset) |-> hi_cnt_ff >= 192)
    else $error("internal reset after too short a pin hold");
  a_reset_release: assert property (!i_reset_pin [*5] |-> !o_core_reset)
    else $error("internal reset held after pin went low");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr > 8'h0F |=> o_reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_oe_follow: assert property (i_reg_wr && i_reg_addr == rcs_pkg::OFS_P1 && !o_core_reset
    && !i_reset_pin |-> ##2 o_p1_pin_oe == ~$past(i_reg_wdata, 2))
    else $error("port one drive does not follow latch");
  a_pd_halt: assert property (o_osc_stop |-> o_cpu_halt && !o_periph_run)
    else $error("power-down leaves functions running");
  a_pd_osc_out: assert property (o_osc_stop [*2] |-> !o_osc_output_pin)
    else $error("oscillator output active in power-down");
  a_idle_run: assert property (o_cpu_halt && !o_osc_stop |-> o_periph_run)
    else $error("peripherals stopped in idle");
  a_alt_copy: assert property (o_serial_rx == $past(i_p3_pin[0], 3)
    && o_timer_one_count_in == $past(i_p3_pin[5], 3))
    else $error("alternate inputs do not follow port three");
  a_irq_quiet: assert property (i_irq_req == 5'h00 |=> !o_irq_valid)
    else $error("interrupt valid without request");
  c_full_reset: cover property ($rose(o_core_reset));
  c_idle: cover property (o_cpu_halt && o_periph_run);
  c_power_down: cover property (o_osc_stop);
endmodule : rcs_props
bind rcs_top rcs_props i_props (.i_core_clk, .i_rst_b, .i_reset_pin, .i_p3_pin, .i_irq_req,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_p1_pin_oe, .o_p3_pin_oe, .o_serial_rx,
  .o_timer_one_count_in, .o_irq_valid, .o_mcycle, .o_core_reset, .o_cpu_halt, .o_periph_run,
  .o_osc_stop, .o_osc_output_pin, .o_reg_rdata);
`default_nettype wire

/* verification/rcs_board.sv */
// Board model: oscillator source and reset pin driver.
`timescale 1ns/1ns
`default_nettype none
module rcs_board #(
  parameter int HALF_NS = 40
) (
  input  wire logic i_osc_stop,
  output logic      o_osc,
  output logic      o_reset_pin
);
  // The crystal freezes while the device holds it stopped.
  initial begin
    o_osc = 1'b0;
    o_reset_pin = 1'b0;
    #3;
    forever begin
      #HALF_NS;
      if (!i_osc_stop) o_osc = ~o_osc;
    end
  end
  task automatic hold_reset(input int n_osc);
    #3 o_reset_pin = 1'b1;
    repeat (n_osc) @(posedge o_osc);
    o_reset_pin = 1'b0;
  endtask : hold_reset
endmodule : rcs_board
`default_nettype wire

/* verification/rcs_top_bench.sv */
// Self-checking bench for the reset, clock and special register block.
`timescale 1ns/1ns
`default_nettype none
module rcs_top_bench;
  localparam int OSC_CYC = 8;
  logic       clk, rst_b, tx, cmp, wr, rd, osc, rpin, seen;
  logic       rx, irq0, irq1, t0, t1, vld, hi, mc, crst, halt, prun, ostop, oout, eh;
  logic [7:0] addr, wdata, p1_ext, p3_ext, rdata, p1_oe, p3_oe, eoe3;
  logic [7:0] exp_r [16];
  logic [4:0] req;
  logic [2:0] vec;
  wire  [7:0] p1_w = p1_ext & ~p1_oe;
  wire  [7:0] p3_w = p3_ext & ~p3_oe;
  int         n_mismatch, checks_done, seed, cyc, cyc0, k, j, ev;
  rcs_board #(.HALF_NS(40)) i_board (.i_osc_stop(ostop), .o_osc(osc), .o_reset_pin(rpin));
  rcs_top i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_reset_pin(rpin), .i_osc_input_pin(osc),
    .o_osc_output_pin(oout), .i_p1_pin(p1_w), .o_p1_pin(), .o_p1_pin_oe(p1_oe),
    .i_p3_pin(p3_w), .o_p3_pin(), .o_p3_pin_oe(p3_oe), .i_comparator_result(cmp),
    .i_serial_tx(tx), .o_serial_rx(rx), .o_ext_irq_zero(irq0), .o_ext_irq_one(irq1),
    .o_timer_zero_count_in(t0), .o_timer_one_count_in(t1), .i_irq_req(req),
    .o_irq_valid(vld), .o_irq_vec(vec), .o_irq_high(hi), .o_mcycle(mc), .o_core_reset(crst),
    .o_cpu_halt(halt), .o_periph_run(prun), .o_osc_stop(ostop), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic want);
    chk8({7'h00, got}, {7'h00, want});
  endtask : chk1
  function automatic logic [7:0] msk(input logic [7:0] a);
    if (a == rcs_pkg::OFS_IP) return rcs_pkg::IP_MASK;
    if (a == rcs_pkg::OFS_IE) return rcs_pkg::IE_MASK;
    if (a == rcs_pkg::OFS_PWR) return rcs_pkg::PWR_MASK;
    return 8'hFF;
  endfunction : msk
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == rcs_pkg::OFS_P1) return p1_ext & exp_r[13];
    if (a == rcs_pkg::OFS_P3) return {p3_ext[7] & exp_r[14][7], cmp,
      p3_ext[5:0] & exp_r[14][5:0] & {4'hF, tx, 1'b1}};
    return (a < 8'h10) ? exp_r[a[3:0]] : 8'h00;
  endfunction : exp_rd
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 8'h10) exp_r[a[3:0]] = d & msk(a);
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(rdata, exp_rd(a));
  endtask : rd_chk
  task automatic sweep;
    for (k = 0; k <= 16; k++) rd_chk(8'(k));
  endtask : sweep
  task automatic wait_mc;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (mc === 1'b1) break;
    end
  endtask : wait_mc
  initial begin
    seed = 32'h32EA3CC0;
    {rst_b, wr, rd, cmp, seen} = 5'h00;
    {addr, wdata, req, cyc, n_mismatch, checks_done} = '0;
    {p1_ext, p3_ext, tx} = 17'h1FFFF;
    for (k = 0; k < 16; k++) exp_r[k] = (k == 13 || k == 14) ? 8'hFF : 8'h00;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    sweep();
    chk8(p1_oe, 8'h00);
    for (k = 0; k <= 12; k++) wr_reg(8'(k), 8'($random(seed)));
    wr_reg(8'h20, 8'h00);
    for (k = 0; k <= 12; k++) rd_chk(8'(k));
    rd_chk(8'h20);
    // Ports: the latch sets the pull-down, the pin level comes back on read.
    for (j = 0; j < 6; j++) begin
      @(posedge clk);
      p1_ext <= 8'($random(seed));
      p3_ext <= 8'($random(seed));
      cmp    <= 1'($random(seed));
      tx     <= 1'($random(seed));
      wr_reg(rcs_pkg::OFS_P1, 8'($random(seed)));
      wr_reg(rcs_pkg::OFS_P3, 8'($random(seed)));
      repeat (6) @(posedge clk);
      #1;
      eoe3 = ~exp_r[14] & 8'hBF | {6'h00, ~tx, 1'b0};
      chk8(p1_oe, ~exp_r[13]);
      chk8(p3_oe, eoe3);
      eoe3 = p3_ext & ~eoe3;
      chk8({3'h0, rx, irq0, irq1, t0, t1}, {3'h0, eoe3[0], eoe3[2], eoe3[3], eoe3[4], eoe3[5]});
      rd_chk(rcs_pkg::OFS_P1);
      rd_chk(rcs_pkg::OFS_P3);
    end
    wr_reg(rcs_pkg::OFS_IE, 8'h9F);
    for (j = 0; j < 8; j++) begin
      wr_reg(rcs_pkg::OFS_IP, 8'($random(seed)));
      @(posedge clk);
      req <= 5'($random(seed));
      repeat (2) @(posedge clk);
      #1;
      ev = 8;
      for (k = 4; k >= 0; k--) if (req[k] && exp_r[11][k]) ev = k;
      eh = (ev < 8);
      if (!eh) for (k = 4; k >= 0; k--) if (req[k]) ev = k;
      chk1(vld, req != 5'h00);
      if (req != 5'h00) chk8({4'h0, hi, vec}, {4'h0, eh, 3'(ev)});
    end
    @(posedge clk);
    req <= 5'h00;
    wr_reg(rcs_pkg::OFS_IE, 8'h81);
    wr_reg(rcs_pkg::OFS_PWR, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk8({5'h00, halt, prun, ostop}, 8'h06);
    @(posedge clk);
    req <= 5'h01;
    repeat (4) @(posedge clk);
    #1;
    chk1(halt, 1'b0);
    req <= 5'h00;
    exp_r[15] = 8'h00;
    rd_chk(rcs_pkg::OFS_PWR);
    wait_mc();
    cyc0 = cyc;
    wait_mc();
    chk8(8'(cyc - cyc0), 8'(rcs_pkg::OSC_PER_MC * OSC_CYC));
    // A hold shorter than two machine cycles presets the ports but must not reset the core.
    fork
      i_board.hold_reset(20);
      repeat (200) begin
        @(posedge clk);
        #1;
        if (crst) seen = 1'b1;
      end
    join
    chk1(seen, 1'b0);
    exp_r[13] = 8'hFF;
    exp_r[14] = 8'hFF;
    chk8(p1_oe, 8'h00);
    wr_reg(rcs_pkg::OFS_P1, 8'h00);
    wr_reg(rcs_pkg::OFS_PWR, 8'h02);
    repeat (4) @(posedge clk);
    #1;
    chk8({4'h0, halt, prun, ostop, oout}, 8'h0A);
    fork
      i_board.hold_reset(48);
      begin
        #6;
        chk8(p1_oe, 8'h00);
        repeat (520) begin
          @(posedge clk);
          #1;
          if (crst) seen = 1'b1;
        end
      end
    join
    chk1(seen, 1'b1);
    chk1(crst, 1'b0);
    chk1(ostop, 1'b0);
    for (k = 0; k < 16; k++) exp_r[k] = (k == 13 || k == 14) ? 8'hFF : 8'h00;
    sweep();
    report_and_stop();
  end
endmodule : rcs_top_bench
`default_nettype wire
